//--- core/crc_unit_core.sv
// CRC execution unit: registers, input FIFO, two-entry buffer, CRC32 engine
`timescale 1ns/1ps

// Contract
// R1 - Integrity check runs raw CRC over message plus CRC, compares with residue.
// R2 - Check result reported by error interrupt or by status writeback, never both; code also sets status bits 59-60 to failed when the error interrupt fires.
// R3 - Writeback reporting masks check-fail source; completion then proceeds normally.
// R4 - Unmasked check failure raises error, suppresses done; pass completes normally.
// R5 - Mode written first; writing it once processing started gives context error.
// R6 - Data size write starts busy processing; non-multiple of 8 bits flags error.
// R7 - Reset control bit 61 clears done, error outputs and interrupt status.
// R8 - Status bits 48-55 report dwords held in the input FIFO.
// R9 - Status bit 58 shows error halt, masked too; stays until reset.
// R10 - Status bits 59-60: 00 none, 01 passed, 10 failed, 11 reserved.
// R11 - Status bit 61 mirrors error output, bit 62 mirrors done output.
// R12 - Status bit 63 reads zero during reset sequence, one afterward.
// R13 - Interrupt status bit sets only when unmasked; masked bit reads zero.
// R14 - Nonzero interrupt status halts the unit and asserts error interrupt.
// R15 - In channel-driven operation an error also signals the owning channel.
// R16 - Mask register holds one enable-low bit per error source.
// R17 - Reading a unit register during computation raises early-read error; code raises it only for mode, key size, data size and context reads.
// R18 - Changing key, key size, data size or mode while busy: context error.
// R19 - Access to an illegal location in the unit range raises address error.
// R20 - Pushing into a full input FIFO raises input-overflow error.
// R21 - Integrity value size register discards writes, reads zero, context checked.
// R22 - Partial word and check wait for end-of-message write; it reads zero.
// R23 - Host writes end-of-message to finish; channel issues it automatically.
module crc_unit_core (
	// Clock and reset
	input  wire logic                CLK_I,
	input  wire logic                RESET_N_I,
	// Register access
	input  wire crc_unit_pkg::crc_unit_req_s REG_REQ_I,
	output      crc_unit_pkg::crc_unit_rsp_s REG_RSP_O,
	// Controller and channel signals
	input  wire logic                CH_DRIVEN_I,
	output      logic                DONE_IRQ_O,
	output      logic                ERR_IRQ_O,
	output      logic                CH_ERR_O,
	output      logic                RESET_DONE_O
);

	typedef struct packed {
		crc_unit_pkg::crc_unit_state_e   state;
		logic [3:0]              init_cnt;
		logic [2:0]              mode;
		logic [63:0]             dsize;
		logic [31:0]             crc;
		logic [63:0]             mask;
		logic [63:0]             isr;
		logic                    done;
		logic                    err_irq;
		logic                    ch_err;
		logic                    halt;
		logic                    eom;
		logic [1:0]              integrity_compare_result;
		crc_unit_pkg::crc_unit_word_s [crc_unit_pkg::FIFO_DEPTH-1:0] fifo;
		logic [3:0]              wp;
		logic [3:0]              rp;
		logic [4:0]              cnt;
		logic [63:0]             stg;
		logic [7:0]              stg_be;
		crc_unit_pkg::crc_unit_word_s [1:0] bf;
		logic                    bwp;
		logic                    brp;
		logic [1:0]              bcnt;
		logic [63:0]             cur;
		logic [3:0]              left;
		crc_unit_pkg::crc_unit_rsp_s     rsp;
	} crc_unit_core_s;

	localparam crc_unit_core_s CORE_RST = '{
		state:   crc_unit_pkg::ST_INIT,
		crc:     crc_unit_pkg::CTX_RST,
		mask:    crc_unit_pkg::MASK_RST,
		integrity_compare_result:    crc_unit_pkg::INTEGRITY_COMPARE_RESULT_NONE,
		default: '0
	};

	crc_unit_core_s           s_ff;
	crc_unit_core_s           nxt_s;
	logic [63:0]          ev;
	logic [63:0]          rdat;
	logic                 hit;
	logic                 wr;
	logic                 rd;
	logic                 busy;
	logic                 ri;
	logic                 push;
	logic                 push_ok;
	logic                 mv;
	logic                 tk;
	logic                 halt_ev;
	crc_unit_pkg::crc_unit_word_s pw;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h0, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ crc_unit_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [3:0] bytes_set(input logic [7:0] be);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, be[i]};
		end
		return n;
	endfunction

	always_comb begin
		nxt_s   = s_ff;
		ev      = '0;
		rdat    = '0;
		ri      = 1'b0;
		push    = 1'b0;
		pw      = '0;
		hit     = REG_REQ_I.addr[17:12] == crc_unit_pkg::UNIT_PAGE;
		wr      = REG_REQ_I.wr && hit && s_ff.state != crc_unit_pkg::ST_INIT;
		rd      = REG_REQ_I.rd && hit;
		busy    = s_ff.state == crc_unit_pkg::ST_RUN || s_ff.state == crc_unit_pkg::ST_CHECK;
		// Register decode
		case (REG_REQ_I.addr)
			crc_unit_pkg::OFS_MODE: begin
				if (wr) begin
					ev[crc_unit_pkg::ERR_CE] = busy; // R5 R18
					ev[crc_unit_pkg::ERR_ME] = |(REG_REQ_I.wdata & ~crc_unit_pkg::MODE_LEGAL);
					ev[crc_unit_pkg::ERR_PE] = |REG_REQ_I.wdata[crc_unit_pkg::MODE_POLY_LSB +: 2];
					nxt_s.mode = REG_REQ_I.wdata[2:0];
				end
				ev[crc_unit_pkg::ERR_ERE] = rd && busy; // R17
				rdat = {61'h0, s_ff.mode};
			end
			crc_unit_pkg::OFS_KEY_SIZE: begin
				if (wr) begin
					ev[crc_unit_pkg::ERR_CE]  = busy; // R18
					ev[crc_unit_pkg::ERR_KSE] = REG_REQ_I.wdata != 64'h0;
				end
				ev[crc_unit_pkg::ERR_ERE] = rd && busy; // R17
			end
			crc_unit_pkg::OFS_KEY: begin
				ev[crc_unit_pkg::ERR_CE] = wr && busy; // R18
				ev[crc_unit_pkg::ERR_AE] = rd; // R19
			end
			crc_unit_pkg::OFS_DATA_SIZE: begin
				if (wr) begin
					ev[crc_unit_pkg::ERR_CE]  = busy && REG_REQ_I.wdata != s_ff.dsize; // R18
					ev[crc_unit_pkg::ERR_DSE] = REG_REQ_I.wdata[2:0] != 3'h0; // R6
					nxt_s.dsize = REG_REQ_I.wdata;
					if (s_ff.state == crc_unit_pkg::ST_IDLE) begin
						nxt_s.state = crc_unit_pkg::ST_RUN; // R6
					end
				end
				ev[crc_unit_pkg::ERR_ERE] = rd && busy; // R17
				rdat = s_ff.dsize;
			end
			crc_unit_pkg::OFS_RESET_CTRL: begin
				ri = wr && REG_REQ_I.wdata[crc_unit_pkg::RI_BIT]; // R7
			end
			crc_unit_pkg::OFS_STATUS: begin
				rdat[crc_unit_pkg::IFL_LSB +: 8]  = {3'h0, s_ff.cnt}; // R8
				rdat[crc_unit_pkg::ST_HALTED]     = s_ff.halt; // R9
				rdat[crc_unit_pkg::INTEGRITY_COMPARE_RESULT_LSB +: 2] = s_ff.integrity_compare_result; // R10
				rdat[crc_unit_pkg::ST_EI]         = s_ff.err_irq; // R11
				rdat[crc_unit_pkg::ST_DI]         = s_ff.done; // R11
				rdat[crc_unit_pkg::ST_RD]         = s_ff.state != crc_unit_pkg::ST_INIT; // R12
			end
			crc_unit_pkg::OFS_ISR: begin
				rdat = s_ff.isr;
			end
			crc_unit_pkg::OFS_MASK: begin
				if (wr) begin
					nxt_s.mask = REG_REQ_I.wdata & crc_unit_pkg::ERR_IMPL; // R16
				end
				rdat = s_ff.mask;
			end
			crc_unit_pkg::OFS_ICV_SIZE: begin
				ev[crc_unit_pkg::ERR_CE] = wr && busy; // R21
			end
			crc_unit_pkg::OFS_EOM: begin
				if (wr) begin
					nxt_s.eom = 1'b1; // R22
					if (s_ff.stg_be != 8'h0) begin
						push      = 1'b1;
						pw.data   = s_ff.stg;
						pw.nbytes = bytes_set(s_ff.stg_be);
						nxt_s.stg    = '0;
						nxt_s.stg_be = '0;
					end
				end
			end
			crc_unit_pkg::OFS_CONTEXT: begin
				if (wr) begin
					ev[crc_unit_pkg::ERR_CE] = busy; // R18
					nxt_s.crc = REG_REQ_I.wdata[63:32];
				end
				ev[crc_unit_pkg::ERR_ERE] = rd && busy; // R17
				rdat = {s_ff.crc, 32'h0};
			end
			default: begin
				if (REG_REQ_I.addr[17:11] == crc_unit_pkg::FIFO_PAGE && !rd) begin
					if (wr) begin
						ev[crc_unit_pkg::ERR_AE] = |(s_ff.stg_be & REG_REQ_I.be);
						for (int i = 0; i < 8; i++) begin
							if (REG_REQ_I.be[i]) begin
								nxt_s.stg[8*i +: 8] = REG_REQ_I.wdata[8*i +: 8];
							end
						end
						nxt_s.stg_be = s_ff.stg_be | REG_REQ_I.be;
						if (nxt_s.stg_be == 8'hFF) begin
							push         = 1'b1;
							pw.data      = nxt_s.stg;
							pw.nbytes    = 4'h8;
							nxt_s.stg    = '0;
							nxt_s.stg_be = '0;
						end
					end
				end else begin
					ev[crc_unit_pkg::ERR_AE] = wr || rd; // R19
				end
			end
		endcase
		nxt_s.rsp.rvalid = rd;
		nxt_s.rsp.rdata  = rdat;
		// Input FIFO push, overflow when full
		push_ok = push && s_ff.cnt != crc_unit_pkg::FIFO_FULL;
		ev[crc_unit_pkg::ERR_IPO] = push && !push_ok; // R20
		if (push_ok) begin
			nxt_s.fifo[s_ff.wp] = pw;
			nxt_s.wp = s_ff.wp + 4'h1;
		end
		// FIFO to buffer, buffer to engine
		mv = s_ff.cnt != 5'h0 && s_ff.bcnt != 2'h2 && s_ff.state != crc_unit_pkg::ST_HALT;
		tk = s_ff.state == crc_unit_pkg::ST_RUN && s_ff.left == 4'h0 && s_ff.bcnt != 2'h0;
		if (mv) begin
			nxt_s.bf[s_ff.bwp] = s_ff.fifo[s_ff.rp];
			nxt_s.bwp = ~s_ff.bwp;
			nxt_s.rp  = s_ff.rp + 4'h1;
		end
		if (tk) begin
			nxt_s.cur  = s_ff.bf[s_ff.brp].data;
			nxt_s.left = s_ff.bf[s_ff.brp].nbytes;
			nxt_s.brp  = ~s_ff.brp;
		end
		nxt_s.cnt  = s_ff.cnt + {4'h0, push_ok} - {4'h0, mv};
		nxt_s.bcnt = s_ff.bcnt + {1'b0, mv} - {1'b0, tk};
		// Engine
		case (s_ff.state)
			crc_unit_pkg::ST_INIT: begin
				nxt_s.init_cnt = s_ff.init_cnt + 4'h1;
				if (s_ff.init_cnt == crc_unit_pkg::RST_SEQ_CYC - 4'h1) begin
					nxt_s.state = crc_unit_pkg::ST_IDLE; // R12
				end
			end
			crc_unit_pkg::ST_RUN: begin
				if (s_ff.left != 4'h0) begin
					nxt_s.crc  = crc_byte(s_ff.crc, s_ff.cur[7:0]);
					nxt_s.cur  = s_ff.cur >> 8;
					nxt_s.left = s_ff.left - 4'h1;
				end else if (s_ff.eom && s_ff.cnt == 5'h0 && s_ff.bcnt == 2'h0
						&& s_ff.stg_be == 8'h0 && !push) begin
					if (s_ff.mode[crc_unit_pkg::MODE_CICV]) begin
						nxt_s.state = crc_unit_pkg::ST_CHECK; // R22
					end else begin
						nxt_s.state = crc_unit_pkg::ST_DONE;
						nxt_s.done  = 1'b1;
					end
				end
			end
			crc_unit_pkg::ST_CHECK: begin
				if (s_ff.crc == crc_unit_pkg::CRC_RESIDUE) begin // R1
					nxt_s.integrity_compare_result  = crc_unit_pkg::INTEGRITY_COMPARE_RESULT_PASS; // R10
					nxt_s.state = crc_unit_pkg::ST_DONE;
					nxt_s.done  = 1'b1; // R4
				end else begin
					nxt_s.integrity_compare_result = crc_unit_pkg::INTEGRITY_COMPARE_RESULT_FAIL; // R10
					ev[crc_unit_pkg::ERR_ICE] = 1'b1;
					if (s_ff.mask[crc_unit_pkg::ERR_ICE]) begin
						nxt_s.state = crc_unit_pkg::ST_DONE; // R3
						nxt_s.done  = 1'b1; // R2 R3
					end
				end
			end
			crc_unit_pkg::ST_IDLE, crc_unit_pkg::ST_DONE, crc_unit_pkg::ST_HALT: begin
				nxt_s.init_cnt = s_ff.init_cnt;
			end
			default: begin
				nxt_s.state = crc_unit_pkg::ST_HALT;
			end
		endcase
		// Re-initialisation
		if (ri) begin
			nxt_s          = CORE_RST; // R7
			nxt_s.mask     = s_ff.mask;
			nxt_s.mode     = s_ff.mode;
			nxt_s.rsp      = s_ff.rsp;
			nxt_s.rsp.rvalid = 1'b0;
		end
		// Error capture, set wins over clear
		nxt_s.isr = (ri ? 64'h0 : s_ff.isr) | (ev & ~s_ff.mask); // R13
		nxt_s.isr = nxt_s.isr & ~nxt_s.mask; // R13
		halt_ev = |(ev & ~({63'h0, s_ff.mask[crc_unit_pkg::ERR_ICE]} << crc_unit_pkg::ERR_ICE));
		if (halt_ev || nxt_s.isr != 64'h0) begin
			nxt_s.halt  = 1'b1; // R9
			nxt_s.state = crc_unit_pkg::ST_HALT; // R14
			nxt_s.done  = 1'b0; // R4
		end
		nxt_s.err_irq = |nxt_s.isr; // R14
		nxt_s.ch_err  = (|nxt_s.isr) && CH_DRIVEN_I; // R15
	end

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			s_ff <= CORE_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign REG_RSP_O    = s_ff.rsp;
	assign DONE_IRQ_O   = s_ff.done; // R11
	assign ERR_IRQ_O    = s_ff.err_irq; // R11
	assign CH_ERR_O     = s_ff.ch_err;
	assign RESET_DONE_O = s_ff.state != crc_unit_pkg::ST_INIT; // R12

	// Checks
	sequence s_check_fail;
		s_ff.state == crc_unit_pkg::ST_CHECK && s_ff.crc != crc_unit_pkg::CRC_RESIDUE
			&& !s_ff.mask[crc_unit_pkg::ERR_ICE];
	endsequence

	sequence s_fail_reported;
		!DONE_IRQ_O && s_ff.integrity_compare_result == crc_unit_pkg::INTEGRITY_COMPARE_RESULT_FAIL ##0 ERR_IRQ_O [*2];
	endsequence

	property p_fail_no_done;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		s_check_fail |=> s_fail_reported;
	endproperty
	a_fail_no_done: assert property (p_fail_no_done) else $error("check fail not reported"); // R4

	property p_pass_done;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		s_ff.state == crc_unit_pkg::ST_CHECK && s_ff.crc == crc_unit_pkg::CRC_RESIDUE && !ri
			|=> DONE_IRQ_O && s_ff.integrity_compare_result == crc_unit_pkg::INTEGRITY_COMPARE_RESULT_PASS && !ERR_IRQ_O;
	endproperty
	a_pass_done: assert property (p_pass_done) else $error("passing check not done"); // R1

	property p_ri_clears;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		ri && s_ff.state != crc_unit_pkg::ST_CHECK |=> !DONE_IRQ_O && !ERR_IRQ_O && s_ff.isr == 64'h0;
	endproperty
	a_ri_clears: assert property (p_ri_clears) else $error("reset interrupt ineffective"); // R7

	property p_ifl;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		rd && REG_REQ_I.addr == crc_unit_pkg::OFS_STATUS
			|=> REG_RSP_O.rvalid && REG_RSP_O.rdata[55:48] == {3'h0, $past(s_ff.cnt)};
	endproperty
	a_ifl: assert property (p_ifl) else $error("fifo level field wrong"); // R8

	property p_isr_halts;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		s_ff.isr != 64'h0 |-> ERR_IRQ_O && s_ff.halt && s_ff.state == crc_unit_pkg::ST_HALT;
	endproperty
	a_isr_halts: assert property (p_isr_halts) else $error("nonzero status without halt"); // R14

	property p_masked_zero;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(s_ff.isr & s_ff.mask) == 64'h0;
	endproperty
	a_masked_zero: assert property (p_masked_zero) else $error("masked status bit set"); // R13

	property p_dsize_start;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		wr && REG_REQ_I.addr == crc_unit_pkg::OFS_DATA_SIZE && s_ff.state == crc_unit_pkg::ST_IDLE
			&& REG_REQ_I.wdata[2:0] == 3'h0 && !mv && !tk
			|=> s_ff.state == crc_unit_pkg::ST_RUN ##1 s_ff.state != crc_unit_pkg::ST_IDLE;
	endproperty
	a_dsize_start: assert property (p_dsize_start) else $error("data size write did not start"); // R6

	property p_dse;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		wr && REG_REQ_I.addr == crc_unit_pkg::OFS_DATA_SIZE && REG_REQ_I.wdata[2:0] != 3'h0
			&& !s_ff.mask[crc_unit_pkg::ERR_DSE] |=> s_ff.isr[crc_unit_pkg::ERR_DSE] ##1 ERR_IRQ_O;
	endproperty
	a_dse: assert property (p_dse) else $error("data size error missed"); // R6

	property p_ipo;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		push && s_ff.cnt == crc_unit_pkg::FIFO_FULL && !s_ff.mask[crc_unit_pkg::ERR_IPO]
			|=> s_ff.isr[crc_unit_pkg::ERR_IPO] && s_ff.cnt == $past(s_ff.cnt) - {4'h0, $past(mv)};
	endproperty
	a_ipo: assert property (p_ipo) else $error("overflow not flagged"); // R20

	property p_ere;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		rd && busy && (REG_REQ_I.addr == crc_unit_pkg::OFS_CONTEXT
			|| REG_REQ_I.addr == crc_unit_pkg::OFS_DATA_SIZE || REG_REQ_I.addr == crc_unit_pkg::OFS_MODE)
			&& !s_ff.mask[crc_unit_pkg::ERR_ERE] |=> s_ff.isr[crc_unit_pkg::ERR_ERE];
	endproperty
	a_ere: assert property (p_ere) else $error("early read not flagged"); // R17

	property p_icv_zero;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		rd && (REG_REQ_I.addr == crc_unit_pkg::OFS_ICV_SIZE || REG_REQ_I.addr == crc_unit_pkg::OFS_EOM)
			|=> REG_RSP_O.rdata == 64'h0;
	endproperty
	a_icv_zero: assert property (p_icv_zero) else $error("size or end register nonzero"); // R21
endmodule

//--- core/crc_unit_pkg.sv
// Constants, register map and carrier types of the CRC execution unit
package crc_unit_pkg;
	// Address decode
	localparam logic [5:0]  UNIT_PAGE      = 6'h3F;
	localparam logic [6:0]  FIFO_PAGE      = 7'h7F;
	localparam logic [17:0] OFS_MODE       = 18'h3F000;
	localparam logic [17:0] OFS_KEY_SIZE   = 18'h3F008;
	localparam logic [17:0] OFS_DATA_SIZE  = 18'h3F010;
	localparam logic [17:0] OFS_RESET_CTRL = 18'h3F018;
	localparam logic [17:0] OFS_STATUS     = 18'h3F028;
	localparam logic [17:0] OFS_ISR        = 18'h3F030;
	localparam logic [17:0] OFS_MASK       = 18'h3F038;
	localparam logic [17:0] OFS_ICV_SIZE   = 18'h3F040;
	localparam logic [17:0] OFS_EOM        = 18'h3F050;
	localparam logic [17:0] OFS_CONTEXT    = 18'h3F100;
	localparam logic [17:0] OFS_KEY        = 18'h3F400;
	// Reset control and status fields
	localparam int unsigned RI_BIT   = 61;
	localparam int unsigned IFL_LSB  = 48;
	localparam int unsigned ST_HALTED = 58;
	localparam int unsigned INTEGRITY_COMPARE_RESULT_LSB = 59;
	localparam int unsigned ST_EI    = 61;
	localparam int unsigned ST_DI    = 62;
	localparam int unsigned ST_RD    = 63;
	// Error sources, shared by mask and interrupt status
	localparam int unsigned ERR_ICE = 49;
	localparam int unsigned ERR_PE  = 50;
	localparam int unsigned ERR_IE  = 51;
	localparam int unsigned ERR_ERE = 52;
	localparam int unsigned ERR_CE  = 53;
	localparam int unsigned ERR_KSE = 54;
	localparam int unsigned ERR_DSE = 55;
	localparam int unsigned ERR_ME  = 56;
	localparam int unsigned ERR_AE  = 57;
	localparam int unsigned ERR_IPO = 61;
	localparam logic [63:0] ERR_IMPL = 64'h23FE_0000_0000_0000;
	localparam logic [63:0] MASK_RST = 64'h0;
	// Mode fields
	localparam logic [63:0] MODE_LEGAL    = 64'h7;
	localparam int unsigned MODE_CICV     = 0;
	localparam int unsigned MODE_POLY_LSB = 1;
	// CRC32
	localparam logic [31:0] CTX_RST     = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
	localparam logic [1:0]  INTEGRITY_COMPARE_RESULT_NONE   = 2'h0;
	localparam logic [1:0]  INTEGRITY_COMPARE_RESULT_PASS   = 2'h1;
	localparam logic [1:0]  INTEGRITY_COMPARE_RESULT_FAIL   = 2'h2;
	// Input FIFO
	localparam int unsigned FIFO_DEPTH = 16;
	localparam logic [4:0]  FIFO_FULL  = 5'h10;
	// Reset sequence timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned RST_SEQ_NS    = 800;
	localparam logic [3:0]  RST_SEQ_CYC   =
		4'((RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [5:0] {
		ST_INIT  = 6'h01,
		ST_IDLE  = 6'h02,
		ST_RUN   = 6'h04,
		ST_CHECK = 6'h08,
		ST_DONE  = 6'h10,
		ST_HALT  = 6'h20
	} crc_unit_state_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [17:0] addr;
		logic [7:0]  be;
		logic [63:0] wdata;
	} crc_unit_req_s;

	typedef struct packed {
		logic        rvalid;
		logic [63:0] rdata;
	} crc_unit_rsp_s;

	typedef struct packed {
		logic [3:0]  nbytes;
		logic [63:0] data;
	} crc_unit_word_s;
endpackage

//--- testbench/crc_unit_host_model.sv
// Host and channel model that drives the CRC unit register bus
`timescale 1ns/1ps
module crc_unit_host_model (
	// Clock
	input  wire logic                clk_i,
	// Channel error input
	input  wire logic                ch_err_i,
	// Register bus
	output      crc_unit_pkg::crc_unit_req_s req_o
);
	logic [63:0] exp_q[$];
	logic [63:0] msk_q[$];
	logic        ch_eu_err;
	logic        wb_en;

	initial begin
		req_o = '0;
		ch_eu_err = 1'b0;
		wb_en = 1'b0;
	end

	// Channel status records unit error
	always @(posedge clk_i) begin
		if (ch_err_i === 1'b1) begin
			ch_eu_err <= 1'b1;
		end
	end

	task automatic clear_ch();
		ch_eu_err = 1'b0;
	endtask

	// One access, unselected lines show inverse of last value
	task automatic bus_cycle(input logic w, input logic [17:0] a, input logic [7:0] be,
	                         input logic [63:0] d);
		@(posedge clk_i);
		#1;
		req_o = '{wr: w, rd: !w, addr: a, be: be, wdata: d};
		@(posedge clk_i);
		#1;
		req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~be, wdata: ~d};
	endtask

	task automatic wr(input logic [17:0] a, input logic [63:0] d);
		bus_cycle(1'b1, a, 8'h00, d);
	endtask

	task automatic rd(input logic [17:0] a, input logic [63:0] e, input logic [63:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus_cycle(1'b0, a, 8'h00, 64'h0);
	endtask

	task automatic push(input logic [63:0] d);
		bus_cycle(1'b1, 18'h3F800, 8'hFF, d);
	endtask

	// Host finishes the message itself
	task automatic eom();
		wr(crc_unit_pkg::OFS_EOM, {$urandom, $urandom});
	endtask

	// Writeback reporting masks the check-fail source
	task automatic set_wb(input logic en);
		wb_en = en;
		wr(crc_unit_pkg::OFS_MASK, en ? (64'h1 << crc_unit_pkg::ERR_ICE) : 64'h0);
	endtask

	// Mode first, then data size
	task automatic start_msg(input logic [63:0] mode);
		wr(crc_unit_pkg::OFS_MODE, mode);
		wr(crc_unit_pkg::OFS_DATA_SIZE, 64'h40);
	endtask
endmodule

//--- testbench/testbench.sv
// Self-checking testbench of the CRC execution unit
`timescale 1ns/1ps
module testbench;
	logic                CLK_I;
	logic                RESET_N_I;
	logic                CH_DRIVEN_I;
	crc_unit_pkg::crc_unit_req_s req;
	crc_unit_pkg::crc_unit_rsp_s rsp;
	logic                done_irq;
	logic                err_irq;
	logic                ch_err;
	logic                reset_done;
	int                  mismatches;
	int                  n_compared;
	int                  cycles;
	logic [63:0]         e;
	logic [63:0]         m;
	logic [63:0]         msg;
	logic [31:0]         crc;
	logic                drv;
	logic [7:0]          st_top[3] = '{8'hC8, 8'hB4, 8'hD0};
	int unsigned         errb[9];

	crc_unit_core DUT (
		.CLK_I       (CLK_I),
		.RESET_N_I   (RESET_N_I),
		.REG_REQ_I   (req),
		.REG_RSP_O   (rsp),
		.CH_DRIVEN_I (CH_DRIVEN_I),
		.DONE_IRQ_O  (done_irq),
		.ERR_IRQ_O   (err_irq),
		.CH_ERR_O    (ch_err),
		.RESET_DONE_O(reset_done)
	);

	crc_unit_host_model host (
		.clk_i   (CLK_I),
		.ch_err_i(ch_err),
		.req_o   (req)
	);

	initial CLK_I = 1'b0;
	always #50 CLK_I = ~CLK_I;

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] crc_bytes(input logic [31:0] c0, input logic [63:0] d);
		logic [31:0] c;
		c = c0;
		for (int i = 0; i < 4; i++) begin
			c = c ^ {24'h0, d[8*i +: 8]};
			for (int b = 0; b < 8; b++) begin
				c = c[0] ? ((c >> 1) ^ crc_unit_pkg::CRC_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction

	// Bounded wait: 0 for reset done, 1 for done or error
	task automatic wait_until(input int sel);
		int k;
		k = 0;
		while (k < 300 && !(sel == 0 ? reset_done === 1'b1 : (done_irq | err_irq) === 1'b1)) begin
			@(negedge CLK_I);
			k++;
		end
		check(64'(k < 300), 64'h1);
	endtask

	task automatic do_ri();
		host.wr(crc_unit_pkg::OFS_RESET_CTRL, 64'h1 << crc_unit_pkg::RI_BIT);
		@(negedge CLK_I);
		check(64'({done_irq, err_irq, reset_done}), 64'h0);
		host.rd(crc_unit_pkg::OFS_STATUS, 64'h0, 64'h8000_0000_0000_0000);
		wait_until(0);
		host.rd(crc_unit_pkg::OFS_ISR, 64'h0, '1);
		host.rd(crc_unit_pkg::OFS_STATUS, 64'h8000_0000_0000_0000, 64'hFCFF_0000_0000_0000);
		host.clear_ch();
		host.wr(crc_unit_pkg::OFS_MODE, 64'h0);
		host.wr(crc_unit_pkg::OFS_KEY_SIZE, 64'h0);
	endtask

	// Read answers checked in order, plus run ceiling
	always @(negedge CLK_I) begin
		cycles++;
		if (rsp.rvalid === 1'b1) begin
			e = host.exp_q.size() > 0 ? host.exp_q.pop_front() : 64'h0;
			m = host.msk_q.size() > 0 ? host.msk_q.pop_front() : 64'h0;
			check(rsp.rdata & m, e & m);
		end
		if (cycles == 10000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	initial begin
		RESET_N_I = 1'b0;
		CH_DRIVEN_I = 1'b0;
		mismatches = 0;
		n_compared = 0;
		cycles = 0;
		errb = '{crc_unit_pkg::ERR_AE, crc_unit_pkg::ERR_KSE, crc_unit_pkg::ERR_ME, crc_unit_pkg::ERR_PE,
			crc_unit_pkg::ERR_DSE, crc_unit_pkg::ERR_CE, crc_unit_pkg::ERR_ERE, crc_unit_pkg::ERR_CE,
			crc_unit_pkg::ERR_IPO};
		void'($urandom(66998));
		repeat (6) @(posedge CLK_I);
		#1;
		RESET_N_I = 1'b1;
		host.rd(crc_unit_pkg::OFS_STATUS, 64'h0, 64'h8000_0000_0000_0000);
		wait_until(0);
		host.rd(crc_unit_pkg::OFS_STATUS, 64'h8000_0000_0000_0000, '1);
		host.rd(crc_unit_pkg::OFS_MASK, crc_unit_pkg::MASK_RST, '1);
		host.wr(crc_unit_pkg::OFS_ICV_SIZE, {$urandom, $urandom});
		host.rd(crc_unit_pkg::OFS_ICV_SIZE, 64'h0, '1);
		host.rd(crc_unit_pkg::OFS_EOM, 64'h0, '1);
		host.wr(crc_unit_pkg::OFS_MASK, '1);
		host.rd(crc_unit_pkg::OFS_MASK, crc_unit_pkg::ERR_IMPL, '1);
		host.rd(18'h3F0F8, 64'h0, '1);
		repeat (3) @(negedge CLK_I);
		check(64'({err_irq, ch_err}), 64'h0);
		host.rd(crc_unit_pkg::OFS_ISR, 64'h0, '1);
		host.rd(crc_unit_pkg::OFS_STATUS, 64'h8400_0000_0000_0000, 64'hE400_0000_0000_0000);
		do_ri();
		host.wr(crc_unit_pkg::OFS_MASK, 64'h0);
		// Pass, unmasked fail, masked fail
		for (int s = 0; s < 3; s++) begin
			msg = {$urandom, $urandom};
			crc = crc_bytes(crc_unit_pkg::CTX_RST, msg);
			host.set_wb(s == 2);
			host.start_msg(64'h1);
			host.wr(crc_unit_pkg::OFS_DATA_SIZE, 64'h40);
			host.push({~crc ^ ((s != 0) ? 32'h1 : 32'h0), msg[31:0]});
			repeat (20) @(negedge CLK_I);
			check(64'({done_irq, err_irq}), 64'h0);
			host.rd(crc_unit_pkg::OFS_STATUS, 64'h0, 64'h7C00_0000_0000_0000);
			host.eom();
			wait_until(1);
			@(negedge CLK_I);
			check(64'({done_irq, err_irq}), (s == 1) ? 64'h1 : 64'h2);
			host.rd(crc_unit_pkg::OFS_STATUS, {st_top[s], 56'h0}, 64'hFC00_0000_0000_0000);
			host.rd(crc_unit_pkg::OFS_ISR, (s == 1) ? 64'h1 << crc_unit_pkg::ERR_ICE : 64'h0, '1);
			do_ri();
		end
		host.set_wb(1'b0);
		// Each error source in turn, except ERR_ICE and ERR_IE
		for (int k = 0; k < 9; k++) begin
			drv = 1'($urandom);
			@(posedge CLK_I);
			#1;
			CH_DRIVEN_I = drv;
			if (k >= 5 && k <= 7) begin
				host.wr(crc_unit_pkg::OFS_DATA_SIZE, 64'h40);
			end
			case (k)
				0: host.rd(18'h3F0F8, 64'h0, '1);
				1: host.wr(crc_unit_pkg::OFS_KEY_SIZE, 64'h1);
				2: host.wr(crc_unit_pkg::OFS_MODE, 64'h8);
				3: host.wr(crc_unit_pkg::OFS_MODE, 64'h2);
				4: host.wr(crc_unit_pkg::OFS_DATA_SIZE, 64'h7);
				5: host.wr(crc_unit_pkg::OFS_MODE, 64'h0);
				6: host.rd(crc_unit_pkg::OFS_DATA_SIZE, 64'h40, '1);
				7: host.wr(crc_unit_pkg::OFS_ICV_SIZE, 64'h0);
				default: begin
					for (int j = 0; j < 20 && err_irq !== 1'b1; j++) begin
						host.push({$urandom, $urandom});
						@(negedge CLK_I);
					end
				end
			endcase
			repeat (4) @(negedge CLK_I);
			check(64'({err_irq, ch_err, host.ch_eu_err}), 64'({1'b1, drv, drv}));
			host.rd(crc_unit_pkg::OFS_ISR, 64'h1 << errb[k], '1);
			e = {8'hA4, (k == 8) ? 8'h10 : 8'h00, 48'h0};
			m = {8'hE4, (k == 8) ? 8'hFF : 8'h00, 48'h0};
			host.rd(crc_unit_pkg::OFS_STATUS, e, m);
			do_ri();
		end
		repeat (5) @(negedge CLK_I);
		check(64'(host.exp_q.size()), 64'h0);
		tally_and_finish();
	end
endmodule
